// ---- rtl/sptr_consts.svh ----
`ifndef SPTR_CONSTS_SVH
`define SPTR_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets (low eight address bits)
// ----------------------------------------------------------------
`define SPTR_OFF_PWD_LO 8'h00
`define SPTR_OFF_PWD_HI 8'h04
`define SPTR_OFF_OPTION 8'h08
`define SPTR_OFF_LOCK 8'h0c
`define SPTR_OFF_SECTOR 8'h10
`define SPTR_OFF_PSTAT 8'h14
`define SPTR_OFF_DSTAT 8'h18
`define SPTR_OFF_PAT_NV 8'h1c
`define SPTR_OFF_PAT_LIVE 8'h20
`define SPTR_OFF_CMD 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPTR_OPT_PERM 0
`define SPTR_OPT_PERSIST 1
`define SPTR_OPT_PWD 2
`define SPTR_OPT_PPB_OTP 3
`define SPTR_OPT_DYB 4
`define SPTR_LOCK_BIT 0
`define SPTR_CMD_ERASE 0

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define SPTR_OPT_RESET 5'h1f
`define SPTR_PWD_RESET 64'hffff_ffff_ffff_ffff
`define SPTR_PWD_UNDEF 32'h0000_0000
`define SPTR_PPB_RESET 16'hffff
`define SPTR_PAT_RESET 8'h00
`define SPTR_STAT_OPEN 8'hff
`define SPTR_STAT_PROT 8'h00

// ----------------------------------------------------------------
// Sizes and latency windows
// ----------------------------------------------------------------
`define SPTR_SECTORS 16
`define SPTR_SDR_WIN 5'h08
`define SPTR_DDR_WIN 5'h04

`endif

// ---- rtl/sptr_pkg.sv ----
package sptr_pkg;

    // Data lines during latency: value on the rising and falling half.
    typedef struct packed {
        logic [3:0] rise;
        logic [3:0] fall;
        logic oe;
    } sptr_dq_t;

    // Latency window request from the command decoder.
    typedef struct packed {
        logic start;
        logic ddr;
        logic eligible;
        logic [4:0] cycles;
    } sptr_lat_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_WAIT
    } sptr_bus_state_t;

endpackage

// ---- rtl/sptr_train_drv.sv ----
`timescale 1ns/1ps
`include "sptr_consts.svh"

module sptr_train_drv (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Latency request and pattern
    input wire sptr_pkg::sptr_lat_t lat,
    input wire logic [7:0] pattern,
    // Data lines
    output sptr_pkg::sptr_dq_t dq
);

    logic [4:0] left_reg;
    logic [3:0] win_reg;
    logic ddr_reg;
    logic [5:0] two_r;
    logic in_win;

    // The first latency cycle is kept free of pattern, which is why the
    // full window needs one cycle more than its length.
    function automatic logic [3:0] win_len(input logic ddr, input logic [4:0] cyc);
        logic [4:0] full;
        logic [4:0] avail;
        full = ddr ? `SPTR_DDR_WIN : `SPTR_SDR_WIN;
        avail = (cyc == 5'h00) ? 5'h00 : cyc - 5'h01;
        win_len = (avail < full) ? avail[3:0] : full[3:0];
    endfunction

    assign two_r = {left_reg, 1'b0};
    assign in_win = (left_reg != 5'h00) && (left_reg <= {1'b0, win_reg});

    always_ff @(posedge clk) begin
        if (rst) begin
            left_reg <= 5'h00;
            win_reg <= 4'h0;
            ddr_reg <= 1'b0;
        end else if (lat.start) begin
            left_reg <= lat.eligible ? lat.cycles : 5'h00;
            win_reg <= win_len(lat.ddr, lat.cycles);
            ddr_reg <= lat.ddr;
        end else if (left_reg != 5'h00) begin
            left_reg <= left_reg - 5'h01;
        end
    end

    // Pattern goes out most significant bit first, the same bit on all lanes.
    always_ff @(posedge clk) begin
        if (rst) begin
            dq <= '0;
        end else if (in_win) begin
            dq.oe <= 1'b1;
            if (ddr_reg) begin
                dq.rise <= {4{pattern[3'(two_r - 6'h01)]}};
                dq.fall <= {4{pattern[3'(two_r - 6'h02)]}};
            end else begin
                dq.rise <= {4{pattern[3'(left_reg - 5'h01)]}};
                dq.fall <= {4{pattern[3'(left_reg - 5'h01)]}};
            end
        end else begin
            dq <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [4:0] oe_cnt_reg;
    logic [4:0] req_cyc_reg;
    logic req_ddr_reg;

    always_ff @(posedge clk) begin
        if (rst || lat.start) begin
            oe_cnt_reg <= 5'h00;
        end else if (dq.oe) begin
            oe_cnt_reg <= oe_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_cyc_reg <= 5'h00;
            req_ddr_reg <= 1'b0;
        end else if (lat.start) begin
            req_cyc_reg <= lat.cycles;
            req_ddr_reg <= lat.ddr;
        end
    end

    a_sdr_full_win: assert property (@(posedge clk) disable iff (rst)
        $fell(dq.oe) && !req_ddr_reg && req_cyc_reg >= 5'd9 |-> oe_cnt_reg == 5'd8)
        else $error("SDR pattern window is not eight cycles");
    a_sdr_short_win: assert property (@(posedge clk) disable iff (rst)
        $fell(dq.oe) && !req_ddr_reg && req_cyc_reg < 5'd9 |-> oe_cnt_reg == req_cyc_reg - 5'd1)
        else $error("short SDR pattern not truncated");
    a_ddr_full_win: assert property (@(posedge clk) disable iff (rst)
        $fell(dq.oe) && req_ddr_reg && req_cyc_reg >= 5'd5 |-> oe_cnt_reg == 5'd4)
        else $error("DDR pattern window is not four cycles");
    a_ddr_short_win: assert property (@(posedge clk) disable iff (rst)
        $fell(dq.oe) && req_ddr_reg && req_cyc_reg < 5'd5 |-> oe_cnt_reg == req_cyc_reg - 5'd1)
        else $error("short DDR pattern not truncated");
    a_pattern_tail: assert property (@(posedge clk) disable iff (rst)
        $fell(dq.oe) && !lat.start |-> $past(dq.fall) == {4{$past(pattern[0])}})
        else $error("pattern does not end on bit zero");
    c_ddr_window: cover property (@(posedge clk) disable iff (rst)
        lat.start && lat.ddr && lat.eligible && lat.cycles == 5'd6 ##4 dq.oe);

endmodule // sptr_train_drv

// ---- rtl/sptr_regs.sv ----
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sptr_consts.svh"

module sptr_regs (
    // Clock and resets
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic PWR_ON_RESET,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Latency window and data lines
    input wire sptr_pkg::sptr_lat_t LAT,
    output sptr_pkg::sptr_dq_t DQ
);

    // ----------------------------------------------------------------
    // Bus phase tracking
    // ----------------------------------------------------------------
    sptr_pkg::sptr_bus_state_t state_reg;
    logic [7:0] addr_reg;
    logic wr_reg;
    logic word_reg;
    logic rst_any;
    logic accept;
    logic do_op;
    logic wr_en;

    assign rst_any = RESET | PWR_ON_RESET;
    assign accept = HSEL && HTRANS[1] && HREADY;
    assign do_op = (state_reg == sptr_pkg::BUS_WAIT);
    assign wr_en = do_op && wr_reg && word_reg;
    assign HREADYOUT = (state_reg == sptr_pkg::BUS_IDLE);
    assign HRESP = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // One wait state lets the read data come from a flip-flop.
    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            state_reg <= sptr_pkg::BUS_IDLE;
        end else begin
            unique case (state_reg)
                sptr_pkg::BUS_IDLE: begin
                    if (accept) begin
                        state_reg <= sptr_pkg::BUS_WAIT;
                    end
                end
                sptr_pkg::BUS_WAIT: begin
                    state_reg <= sptr_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            word_reg <= 1'b0;
        end else if (accept) begin
            addr_reg <= {HADDR[7:2], 2'b00};
            wr_reg <= HWRITE;
            word_reg <= (HSIZE == 3'h2);
        end
    end

    // ----------------------------------------------------------------
    // Protection options and password
    // ----------------------------------------------------------------
    logic [4:0] opt_reg;
    logic [63:0] pwd_reg;
    logic pwd_mode;
    logic opt_wr_ok;

    assign pwd_mode = ~opt_reg[`SPTR_OPT_PWD];
    // Password or persistent mode seals the option bits.
    assign opt_wr_ok = opt_reg[`SPTR_OPT_PWD] & opt_reg[`SPTR_OPT_PERSIST];

    // Stored bits survive a hardware reset; only power-on restores them.
    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            opt_reg <= `SPTR_OPT_RESET;
        end else if (wr_en && opt_wr_ok && hit(addr_reg, `SPTR_OFF_OPTION)) begin
            opt_reg <= opt_reg & HWDATA[4:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            pwd_reg <= `SPTR_PWD_RESET;
        end else if (wr_en && !pwd_mode) begin
            if (hit(addr_reg, `SPTR_OFF_PWD_LO)) begin
                pwd_reg[31:0] <= pwd_reg[31:0] & HWDATA;
            end
            if (hit(addr_reg, `SPTR_OFF_PWD_HI)) begin
                pwd_reg[63:32] <= pwd_reg[63:32] & HWDATA;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lock bit and sector bits
    // ----------------------------------------------------------------
    logic lock_reg;
    logic [3:0] sector_reg;
    logic [`SPTR_SECTORS-1:0] ppb_reg;
    logic [`SPTR_SECTORS-1:0] dyb_reg;
    logic ppb_ok;
    logic ppb_bit;
    logic dyb_bit;

    assign ppb_ok = lock_reg & opt_reg[`SPTR_OPT_PERM];
    assign ppb_bit = ppb_reg[sector_reg];
    assign dyb_bit = dyb_reg[sector_reg];

    // Only a clear is honoured, so software cannot reopen a frozen set.
    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            lock_reg <= 1'b1;
        end else if (RESET) begin
            lock_reg <= opt_reg[`SPTR_OPT_PWD];
        end else if (wr_en && hit(addr_reg, `SPTR_OFF_LOCK) && !HWDATA[`SPTR_LOCK_BIT]) begin
            lock_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            sector_reg <= 4'h0;
        end else if (wr_en && hit(addr_reg, `SPTR_OFF_SECTOR)) begin
            sector_reg <= HWDATA[3:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            ppb_reg <= `SPTR_PPB_RESET;
        end else if (wr_en && ppb_ok) begin
            if (hit(addr_reg, `SPTR_OFF_PSTAT) && HWDATA[7:0] == `SPTR_STAT_PROT) begin
                ppb_reg[sector_reg] <= 1'b0;
            end
            if (hit(addr_reg, `SPTR_OFF_CMD) && HWDATA[`SPTR_CMD_ERASE]
                && opt_reg[`SPTR_OPT_PPB_OTP]) begin
                ppb_reg <= `SPTR_PPB_RESET;
            end
        end
    end

    // Dynamic bits come up all protected when the option bit asks for it.
    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            dyb_reg <= `SPTR_PPB_RESET;
        end else if (RESET) begin
            dyb_reg <= {`SPTR_SECTORS{opt_reg[`SPTR_OPT_DYB]}};
        end else if (wr_en && hit(addr_reg, `SPTR_OFF_DSTAT)) begin
            if (HWDATA[7:0] == `SPTR_STAT_PROT) begin
                dyb_reg[sector_reg] <= 1'b0;
            end else if (HWDATA[7:0] == `SPTR_STAT_OPEN) begin
                dyb_reg[sector_reg] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Training pattern
    // ----------------------------------------------------------------
    logic [7:0] pat_nv_reg;
    logic [7:0] pat_live_reg;

    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            pat_nv_reg <= `SPTR_PAT_RESET;
        end else if (wr_en && hit(addr_reg, `SPTR_OFF_PAT_NV)) begin
            pat_nv_reg <= HWDATA[7:0];
        end
    end

    // A hardware reset reloads the live copy from the stored one.
    always_ff @(posedge REF_CLK) begin
        if (PWR_ON_RESET) begin
            pat_live_reg <= `SPTR_PAT_RESET;
        end else if (RESET) begin
            pat_live_reg <= pat_nv_reg;
        end else if (wr_en && hit(addr_reg, `SPTR_OFF_PAT_LIVE)) begin
            pat_live_reg <= HWDATA[7:0];
        end
    end

    sptr_train_drv u_train (
        .clk(REF_CLK),
        .rst(rst_any),
        .lat(LAT),
        .pattern(pat_live_reg),
        .dq(DQ)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rd_value;

    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (addr_reg)
            `SPTR_OFF_PWD_LO: rd_value = pwd_mode ? `SPTR_PWD_UNDEF : pwd_reg[31:0];
            `SPTR_OFF_PWD_HI: rd_value = pwd_mode ? `SPTR_PWD_UNDEF : pwd_reg[63:32];
            `SPTR_OFF_OPTION: rd_value = {27'h0, opt_reg};
            `SPTR_OFF_LOCK: rd_value = {31'h0, lock_reg};
            `SPTR_OFF_SECTOR: rd_value = {28'h0, sector_reg};
            `SPTR_OFF_PSTAT: rd_value = {24'h0, ppb_bit ? `SPTR_STAT_OPEN : `SPTR_STAT_PROT};
            `SPTR_OFF_DSTAT: rd_value = {24'h0, dyb_bit ? `SPTR_STAT_OPEN : `SPTR_STAT_PROT};
            `SPTR_OFF_PAT_NV: rd_value = {24'h0, pat_nv_reg};
            `SPTR_OFF_PAT_LIVE: rd_value = {24'h0, pat_live_reg};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
            HRDATA <= 32'h0000_0000;
        end else if (do_op && !wr_reg) begin
            HRDATA <= rd_value;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic rd_done;
    assign rd_done = do_op && !wr_reg;

    a_pwd_only_clear: assert property (@(posedge REF_CLK) disable iff (PWR_ON_RESET)
        1'b1 |=> (pwd_reg & ~$past(pwd_reg)) == 64'h0)
        else $error("password bit went from zero to one");
    a_pwd_hidden: assert property (@(posedge REF_CLK) disable iff (rst_any)
        rd_done && pwd_mode && hit(addr_reg, `SPTR_OFF_PWD_HI)
        |=> HRDATA == `SPTR_PWD_UNDEF)
        else $error("password visible in password mode");
    a_pwd_sealed: assert property (@(posedge REF_CLK) disable iff (PWR_ON_RESET)
        wr_en && !opt_reg[`SPTR_OPT_PWD] |=> $stable(pwd_reg))
        else $error("password changed in password mode");
    a_lock_sticky: assert property (@(posedge REF_CLK) disable iff (rst_any)
        !lock_reg |=> !lock_reg [*3])
        else $error("lock bit reopened without reset");
    a_ppb_frozen: assert property (@(posedge REF_CLK) disable iff (PWR_ON_RESET)
        !lock_reg |=> ppb_reg == $past(ppb_reg))
        else $error("persistent bits changed while locked");
    a_pstat_read: assert property (@(posedge REF_CLK) disable iff (rst_any)
        rd_done && hit(addr_reg, `SPTR_OFF_PSTAT)
        |=> HRDATA[7:0] == ($past(ppb_bit) ? 8'hff : 8'h00) && HREADYOUT)
        else $error("persistent status byte wrong");
    a_dstat_read: assert property (@(posedge REF_CLK) disable iff (rst_any)
        rd_done && hit(addr_reg, `SPTR_OFF_DSTAT)
        |=> HRDATA[7:0] == ($past(dyb_bit) ? 8'hff : 8'h00))
        else $error("dynamic status byte wrong");
    a_pat_power_on: assert property (@(posedge REF_CLK)
        PWR_ON_RESET |=> pat_nv_reg == 8'h00 && pat_live_reg == 8'h00)
        else $error("pattern copies not zero after power-on");
    a_pat_reload: assert property (@(posedge REF_CLK)
        RESET && !PWR_ON_RESET |=> pat_live_reg == $past(pat_nv_reg))
        else $error("live pattern not reloaded on reset");
    a_lock_reset: assert property (@(posedge REF_CLK)
        RESET && !PWR_ON_RESET |=> lock_reg == $past(opt_reg[`SPTR_OPT_PWD]))
        else $error("lock bit reset value wrong");
    a_bus_wait: assert property (@(posedge REF_CLK) disable iff (rst_any)
        accept |=> !HREADYOUT ##1 HREADYOUT)
        else $error("bus answer not after one wait state");

    c_pstat_protected: cover property (@(posedge REF_CLK) disable iff (rst_any)
        rd_done && hit(addr_reg, `SPTR_OFF_PSTAT) && !ppb_bit);
    c_lock_cleared: cover property (@(posedge REF_CLK) disable iff (rst_any)
        $fell(lock_reg));
    c_pwd_hidden: cover property (@(posedge REF_CLK) disable iff (rst_any)
        rd_done && pwd_mode && hit(addr_reg, `SPTR_OFF_PWD_LO));
    c_sdr_window: cover property (@(posedge REF_CLK) disable iff (rst_any)
        LAT.start && LAT.eligible && !LAT.ddr && LAT.cycles == 5'd10 ##4 DQ.oe);

endmodule // sptr_regs

// ---- dv/sptr_host_model.sv ----
`timescale 1ns/1ps

module sptr_host_model (
    // Clock
    input wire logic clk,
    // Latency request and returned lanes
    output sptr_pkg::sptr_lat_t lat,
    input wire sptr_pkg::sptr_dq_t dq
);
    logic [15:0] got_bits;
    int got_cycles;
    int lane_err;

    initial begin
        lat = '0;
        got_bits = 16'h0000;
        got_cycles = 0;
        lane_err = 0;
    end

    // ----------------------------------------------------------------
    // Capture
    // ----------------------------------------------------------------
    // Lane 0 bits seen while the device drives are kept and the other lanes are compared to them, so a lane that disagrees shows.
    always @(posedge clk) begin
        if (lat.start) begin
            got_bits = 16'h0000;
            got_cycles = 0;
        end else if (dq.oe === 1'b1) begin
            got_cycles++;
            got_bits = lat.ddr ? {got_bits[13:0], dq.rise[0], dq.fall[0]}
                : {got_bits[14:0], dq.rise[0]};
            if ((!lat.ddr && dq.rise !== dq.fall) || dq.rise !== {4{dq.rise[0]}}
                    || dq.fall !== {4{dq.fall[0]}}) begin
                lane_err++;
            end
        end
    end

    // ----------------------------------------------------------------
    // Request
    // ----------------------------------------------------------------
    task automatic read_latency(input logic ddr, input logic elig, input logic [4:0] cyc);
        lat <= '{1'b1, ddr, elig, cyc};
        @(posedge clk);
        lat.start <= 1'b0;
        repeat (cyc + 2) @(posedge clk);
    endtask
endmodule // sptr_host_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`include "sptr_consts.svh"

module testbench;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic PWR_ON_RESET = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    sptr_pkg::sptr_lat_t LAT;
    sptr_pkg::sptr_dq_t DQ;
    int err_total = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [31:0] pw;
    logic [7:0] pat;
    logic [3:0] sec;

    always #4 REF_CLK = ~REF_CLK;

    sptr_regs dut_u (
        .REF_CLK(REF_CLK), .RESET(RESET), .PWR_ON_RESET(PWR_ON_RESET),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .LAT(LAT), .DQ(DQ)
    );

    sptr_host_model host_u (.clk(REF_CLK), .lat(LAT), .dq(DQ));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("err_total %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The slave's answer time is not assumed; a stuck bus ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                end_sim();
            end
            @(posedge REF_CLK);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [2:0] sz);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h00_0000, a};
        HWRITE <= w;
        HSIZE <= sz;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        rd = HRDATA;
        chk({31'h0, HRESP}, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 3'h2);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 3'h2);
        chk(rd, exp);
    endtask

    task automatic do_reset(input logic por);
        RESET <= 1'b1;
        PWR_ON_RESET <= por;
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        PWR_ON_RESET <= 1'b0;
        @(posedge REF_CLK);
    endtask

    // The first latency cycle never carries pattern, hence the L-1 cap.
    function automatic int exp_win(input logic ddr, input logic elig, input logic [4:0] l);
        int w;
        w = ddr ? 4 : 8;
        if (l - 1 < w) w = l - 1;
        if (!elig) w = 0;
        return w;
    endfunction

    task automatic lat_chk(input logic ddr, input logic elig, input logic [4:0] l);
        int w;
        w = exp_win(ddr, elig, l);
        host_u.read_latency(ddr, elig, l);
        chk(host_u.got_cycles, w);
        chk(host_u.got_bits, pat & ((32'h1 << (ddr ? 2 * w : w)) - 1));
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(95));
        do_reset(1'b1);
        rdc(`SPTR_OFF_PAT_NV, 32'h0000_0000);
        rdc(`SPTR_OFF_PAT_LIVE, 32'h0000_0000);
        rdc(`SPTR_OFF_PSTAT, 32'h0000_00ff);
        rdc(`SPTR_OFF_DSTAT, 32'h0000_00ff);
        rdc(`SPTR_OFF_LOCK, 32'h0000_0001);
        rdc(`SPTR_OFF_PWD_HI, 32'hffff_ffff);
        rdc(8'h3c, 32'h0000_0000);
        pw = $urandom();
        wr(`SPTR_OFF_PWD_LO, pw);
        rdc(`SPTR_OFF_PWD_LO, pw);
        wr(`SPTR_OFF_PWD_LO, 32'hffff_ffff);
        rdc(`SPTR_OFF_PWD_LO, pw);
        sec = 4'($urandom_range(15, 1));
        wr(`SPTR_OFF_SECTOR, {28'h0, sec});
        wr(`SPTR_OFF_PSTAT, 32'h0000_0000);
        wr(`SPTR_OFF_DSTAT, 32'h0000_0000);
        rdc(`SPTR_OFF_PSTAT, 32'h0000_0000);
        rdc(`SPTR_OFF_DSTAT, 32'h0000_0000);
        wr(`SPTR_OFF_CMD, 32'h0000_0001);
        rdc(`SPTR_OFF_PSTAT, 32'h0000_00ff);
        wr(`SPTR_OFF_PSTAT, 32'h0000_0000);
        wr(`SPTR_OFF_DSTAT, 32'h0000_00ff);
        rdc(`SPTR_OFF_DSTAT, 32'h0000_00ff);
        wr(`SPTR_OFF_DSTAT, 32'h0000_0000);
        wr(`SPTR_OFF_SECTOR, 32'h0000_0000);
        rdc(`SPTR_OFF_PSTAT, 32'h0000_00ff);
        wr(`SPTR_OFF_LOCK, 32'h0000_0000);
        rdc(`SPTR_OFF_LOCK, 32'h0000_0000);
        wr(`SPTR_OFF_LOCK, 32'h0000_0001);
        rdc(`SPTR_OFF_LOCK, 32'h0000_0000);
        wr(`SPTR_OFF_PSTAT, 32'h0000_0000);
        rdc(`SPTR_OFF_PSTAT, 32'h0000_00ff);
        do_reset(1'b0);
        rdc(`SPTR_OFF_LOCK, 32'h0000_0001);
        wr(`SPTR_OFF_SECTOR, {28'h0, sec});
        rdc(`SPTR_OFF_PSTAT, 32'h0000_0000);
        rdc(`SPTR_OFF_DSTAT, 32'h0000_00ff);
        pat = 8'($urandom());
        wr(`SPTR_OFF_PAT_LIVE, {24'h0, pat});
        rdc(`SPTR_OFF_PAT_LIVE, {24'h0, pat});
        bus(1'b1, `SPTR_OFF_PAT_LIVE, {24'h0, ~pat}, 3'h0);
        rdc(`SPTR_OFF_PAT_LIVE, {24'h0, pat});
        lat_chk(1'b0, 1'b1, 5'd10);
        lat_chk(1'b0, 1'b1, 5'd9);
        lat_chk(1'b0, 1'b1, 5'd8);
        lat_chk(1'b0, 1'b1, 5'd3);
        lat_chk(1'b1, 1'b1, 5'd6);
        lat_chk(1'b1, 1'b1, 5'd5);
        lat_chk(1'b1, 1'b1, 5'd4);
        lat_chk(1'b1, 1'b1, 5'd2);
        lat_chk(1'b0, 1'b0, 5'd12);
        for (int i = 0; i < 6; i++) begin
            lat_chk(1'($urandom()), 1'b1, 5'($urandom_range(20, 2)));
        end
        wr(`SPTR_OFF_PAT_NV, {24'h0, ~pat});
        do_reset(1'b0);
        pat = ~pat;
        rdc(`SPTR_OFF_PAT_LIVE, {24'h0, pat});
        lat_chk(1'b1, 1'b1, 5'd7);
        wr(`SPTR_OFF_OPTION, 32'hffff_fffb);
        wr(`SPTR_OFF_OPTION, 32'h0000_0000);
        rdc(`SPTR_OFF_OPTION, 32'h0000_001b);
        wr(`SPTR_OFF_PWD_LO, 32'h0000_0000);
        rdc(`SPTR_OFF_PWD_LO, 32'h0000_0000);
        rdc(`SPTR_OFF_PWD_HI, 32'h0000_0000);
        do_reset(1'b0);
        rdc(`SPTR_OFF_LOCK, 32'h0000_0000);
        chk(host_u.lane_err, 0);
        end_sim();
    end
endmodule // testbench
